/* File: hw/fault_flags_and_history.sv */
// Fault flag register and fault history with object access port
`timescale 1ns/1ns
module fault_flags_and_history
  import fault_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] fault_present, // Category fault levels
  input wire logic log_valid, // One-cycle pulse: new fault occurrence
  input wire logic [7:0] log_cause, // Fault cause number
  input wire logic [15:0] log_code, // 16-bit fault code
  input wire logic req_valid, // Object access request pulse
  input wire logic req_write, // 1 write, 0 read
  input wire logic [15:0] req_index, // Object index
  input wire logic [7:0] req_subindex, // Object sub-entry
  input wire logic [31:0] req_wdata, // Write value
  output logic resp_valid, // Answer pulse, one cycle after request
  output logic resp_abort, // Answer is an abort
  output logic [31:0] resp_data, // Read data, zero on abort or write
  output logic [31:0] resp_abort_code, // Abort code, zero when not aborted
  output logic [7:0] fault_flags, // Flag register for process data
  output logic [7:0] fault_log_count // Current fault count
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic resp_valid_q;
  logic resp_abort_q;
  logic [31:0] resp_data_q;
  logic [31:0] resp_code_q;
  logic resp_abort_d;
  logic [31:0] resp_data_d;
  logic [31:0] resp_code_d;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  wire hit_flags = (req_index == IDX_FAULT_FLAGS);
  wire hit_log = (req_index == IDX_FAULT_LOG);
  wire sub_zero = (req_subindex == SUB_COUNT);
  wire sub_entry = (req_subindex >= SUB_FIRST_ENTRY) && (req_subindex <= SUB_LAST_ENTRY);
  wire [7:0] sub_pos = req_subindex - SUB_FIRST_ENTRY;
  wire log_empty = (count_q == COUNT_RESET);
  wire wdata_zero = (req_wdata == 32'h0000_0000);
  wire [31:0] entry_rec;
  wire [31:0] new_rec;
  access_kind_t kind;
  logic [31:0] kind_abort;

  // Sort each request into one kind and, for refusals, its abort code
  always_comb begin
    kind = ACC_ABORT;
    kind_abort = ABORT_NO_OBJECT;
    if (hit_flags) begin
      if (!sub_zero) begin
        kind_abort = ABORT_NO_SUBINDEX;
      end else if (req_write) begin
        kind_abort = ABORT_READ_ONLY;
      end else begin
        kind = ACC_READ_FLAGS;
      end
    end else if (hit_log) begin
      if (sub_zero) begin
        if (!req_write) begin
          kind = ACC_READ_COUNT;
        end else if (wdata_zero) begin
          kind = ACC_CLEAR_LOG;
        end else begin
          kind_abort = ABORT_BAD_VALUE;
        end
      end else if (sub_entry) begin
        if (req_write) begin
          kind_abort = ABORT_READ_ONLY;
        end else if (log_empty) begin
          kind_abort = ABORT_NO_DATA;
        end else begin
          kind = ACC_READ_ENTRY;
        end
      end else begin
        kind_abort = ABORT_NO_SUBINDEX;
      end
    end
  end

  wire clear_log = req_valid && (kind == ACC_CLEAR_LOG);

  // ---------------------------------------------------------------
  // Flag register
  // ---------------------------------------------------------------
  // flags track faults
  assign flags_d = fault_present & FLAGS_LIVE_MASK;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ---------------------------------------------------------------
  // History records
  // ---------------------------------------------------------------
  // record layout
  assign new_rec = (32'(log_cause) << REC_CAUSE_LSB)
                 | (32'(flags_q) << REC_CATEGORY_LSB)
                 | (32'(log_code) << REC_CODE_LSB);

  fault_history u_history (
    .clk(clk),
    .rst(rst),
    .push(log_valid),
    .push_rec(new_rec),
    .clear(clear_log),
    .rd_sel(sub_pos[2:0]),
    .rd_rec(entry_rec)
  );

  // ---------------------------------------------------------------
  // Fault count
  // ---------------------------------------------------------------
  // A fault landing in the clearing cycle is kept: it becomes the first entry
  always_comb begin
    count_d = count_q;
    if (log_valid) begin
      if (clear_log) begin
        count_d = COUNT_ONE;
      end else if (count_q < COUNT_MAX) begin
        count_d = count_q + COUNT_ONE;
      end
    end else if (clear_log) begin
      count_d = COUNT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ---------------------------------------------------------------
  // Response
  // ---------------------------------------------------------------
  // Reads see state as it stood in the request cycle, before any update
  always_comb begin
    resp_abort_d = 1'b0;
    resp_data_d = 32'h0000_0000;
    resp_code_d = 32'h0000_0000;
    case (kind)
      ACC_READ_FLAGS: begin
        resp_data_d = 32'(flags_q);
      end
      ACC_READ_COUNT: begin
        resp_data_d = 32'(count_q);
      end
      ACC_READ_ENTRY: begin
        resp_data_d = entry_rec;
      end
      ACC_CLEAR_LOG: begin
        resp_data_d = 32'h0000_0000;
      end
      ACC_ABORT: begin
        resp_abort_d = 1'b1;
        resp_code_d = kind_abort;
      end
      default: begin
        resp_abort_d = 1'b1;
        resp_code_d = ABORT_NO_OBJECT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_abort_q <= 1'b0;
      resp_data_q <= 32'h0000_0000;
      resp_code_q <= 32'h0000_0000;
    end else begin
      resp_valid_q <= req_valid;
      resp_abort_q <= req_valid && resp_abort_d;
      resp_data_q <= req_valid ? resp_data_d : 32'h0000_0000;
      resp_code_q <= req_valid ? resp_code_d : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign resp_valid = resp_valid_q;
  assign resp_abort = resp_abort_q;
  assign resp_data = resp_data_q;
  assign resp_abort_code = resp_code_q;
  assign fault_flags = flags_q;
  assign fault_log_count = count_q;

endmodule

/* File: hw/fault_pkg.sv */
// Shared constants for the fault flag and fault history block
package fault_pkg;

  // ---------------------------------------------------------------
  // Object indices and sub-entries
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_FAULT_FLAGS = 16'h1001;
  localparam logic [15:0] IDX_FAULT_LOG = 16'h1003;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST_ENTRY = 8'h01;
  localparam logic [7:0] SUB_LAST_ENTRY = 8'h08;

  // ---------------------------------------------------------------
  // Fault flag fields and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_GENERAL = 0;
  localparam int FLAG_OVERCURRENT = 1;
  localparam int FLAG_SUPPLY = 2;
  localparam int FLAG_TEMPERATURE = 3;
  localparam int FLAG_LINK = 4;
  localparam int FLAG_PROFILE = 5;
  localparam int FLAG_UNUSED_SIX = 6;
  localparam int FLAG_VENDOR = 7;
  localparam logic [7:0] FLAGS_LIVE_MASK = 8'hbf;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ---------------------------------------------------------------
  // History record layout, depth and counter
  // ---------------------------------------------------------------
  localparam int REC_CAUSE_LSB = 24;
  localparam int REC_CATEGORY_LSB = 16;
  localparam int REC_CODE_LSB = 0;
  localparam int LOG_DEPTH = 8;
  localparam logic [31:0] REC_RESET = 32'h0000_0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'h08;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ---------------------------------------------------------------
  // Abort codes
  // ---------------------------------------------------------------
  localparam logic [31:0] ABORT_NO_DATA = 32'h0800_0024;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h0609_0011;
  localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h0609_0030;

  typedef enum logic [2:0] {
    ACC_READ_FLAGS,
    ACC_READ_COUNT,
    ACC_READ_ENTRY,
    ACC_CLEAR_LOG,
    ACC_ABORT
  } access_kind_t;

endpackage

/* File: hw/fault_history.sv */
// Eight-deep newest-first fault record stack
`timescale 1ns/1ns
module fault_history
  import fault_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic push, // Log one record this cycle
  input wire logic [31:0] push_rec, // Record to log
  input wire logic clear, // Empty the history
  input wire logic [2:0] rd_sel, // Position minus one
  output logic [31:0] rd_rec // Record at that position
);

  logic [31:0] entry_q [LOG_DEPTH];

  assign rd_rec = entry_q[rd_sel];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // shift and insert
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < LOG_DEPTH; i++) begin
        entry_q[i] <= REC_RESET;
      end
    end else begin
      // Oldest entry falls off the end; a clear in the same cycle wins over the shift
      for (int i = LOG_DEPTH - 1; i > 0; i--) begin
        if (clear) begin
          entry_q[i] <= REC_RESET;
        end else if (push) begin
          entry_q[i] <= entry_q[i-1];
        end
      end
      if (push) begin
        entry_q[0] <= push_rec;
      end else if (clear) begin
        entry_q[0] <= REC_RESET;
      end
    end
  end

endmodule

/* File: tb/fault_checker.sv */
// Concurrent checks on the fault flag and history block ports
`timescale 1ns/1ns
module fault_checker
  import fault_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [7:0] fault_present, // Fault levels
  input wire logic log_valid, // Log pulse
  input wire logic req_valid, // Request pulse
  input wire logic req_write, // Write flag
  input wire logic [15:0] req_index, // Object index
  input wire logic [7:0] req_subindex, // Sub-entry
  input wire logic [31:0] req_wdata, // Write value
  input wire logic resp_valid, // Answer pulse
  input wire logic resp_abort, // Abort flag
  input wire logic [31:0] resp_data, // Read data
  input wire logic [31:0] resp_abort_code, // Abort code
  input wire logic [7:0] fault_flags, // Flag register
  input wire logic [7:0] fault_log_count // Fault count
);
  wire rd = req_valid && !req_write;
  wire on_log = req_index == IDX_FAULT_LOG;
  wire clr = req_valid && req_write && on_log && req_subindex == SUB_COUNT && req_wdata == 32'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_flags_follow: assert property (!$past(rst) |->
    fault_flags == ($past(fault_present) & FLAGS_LIVE_MASK)) else $error("flags lag");
  a_bit_six: assert property (fault_flags[6] == 1'b0) else $error("bit six set");
  a_answer_once: assert property (req_valid |=> resp_valid) else $error("no answer");
  a_no_spurious: assert property (!req_valid |=> !resp_valid) else $error("extra answer");
  a_empty_abort: assert property (rd && on_log && req_subindex inside {[1:8]} &&
    fault_log_count == 8'h00 |=> resp_abort && resp_abort_code == ABORT_NO_DATA)
    else $error("empty read not refused");
  a_count_step: assert property (log_valid && !clr |=> fault_log_count ==
    ($past(fault_log_count) == COUNT_MAX ? COUNT_MAX : $past(fault_log_count) + 8'h01))
    else $error("count step wrong");
  a_clear_zero: assert property (clr && !log_valid |=> fault_log_count == 8'h00)
    else $error("clear ignored");
  a_log_clear: assert property (log_valid && clr |=> fault_log_count == COUNT_ONE)
    else $error("log lost in clear");
  a_count_hold: assert property (!log_valid && !clr |=> $stable(fault_log_count))
    else $error("count moved");
  a_flags_read: assert property (rd && req_index == IDX_FAULT_FLAGS && req_subindex == 8'h00
    |=> resp_data == {24'h0, $past(fault_flags)}) else $error("flag read wrong");
  cover property (log_valid && fault_log_count == COUNT_MAX);
  cover property (resp_abort);
  cover property (clr);
  cover property (log_valid && clr);
endmodule

/* File: tb/obj_master.sv */
// Host-side model issuing object reads and writes
`timescale 1ns/1ns
module obj_master (
  input wire logic clk, // System clock
  output logic req_valid, // Request pulse
  output logic req_write, // Write when high
  output logic [15:0] req_index, // Object index
  output logic [7:0] req_subindex, // Sub-entry
  output logic [31:0] req_wdata // Write value
);
  initial {req_valid, req_write, req_index, req_subindex, req_wdata} = '0;
  task access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
              input logic [31:0] wd);
    @(posedge clk);
    #1;
    {req_valid, req_write, req_index, req_subindex, req_wdata} = {1'b1, w, idx, sub, wd};
    @(posedge clk);
    #1;
    // Idle qualifiers carry the inverse so a stale value cannot pass for a request
    {req_valid, req_write, req_index, req_subindex, req_wdata} = {1'b0, ~w, ~idx, ~sub, ~wd};
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the fault flag and history block
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_top;
  import fault_pkg::*;
  logic clk, rst, log_valid, req_valid, req_write, resp_valid, resp_abort;
  logic [7:0] fault_present, log_cause, req_subindex, fault_flags, fault_log_count, cnt, fl;
  logic [15:0] log_code, req_index;
  logic [31:0] req_wdata, resp_data, resp_abort_code;
  logic [31:0] hist [1:8];
  logic [64:0] exp_q [$];
  logic [64:0] exp_rec;
  int seed = 16;
  int bad_count = 0;
  int check_count = 0;
  obj_master obj_master_i (.clk(clk), .req_valid(req_valid), .req_write(req_write),
    .req_index(req_index), .req_subindex(req_subindex), .req_wdata(req_wdata));
  fault_flags_and_history fault_flags_and_history_i (.clk(clk), .rst(rst),
    .fault_present(fault_present), .log_valid(log_valid), .log_cause(log_cause),
    .log_code(log_code), .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_subindex(req_subindex), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_abort(resp_abort), .resp_data(resp_data), .resp_abort_code(resp_abort_code),
    .fault_flags(fault_flags), .fault_log_count(fault_log_count));
  task summarize;
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task req(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
           input logic ab, input logic [31:0] code, input logic [31:0] rd);
    exp_q.push_back({ab, code, rd});
    obj_master_i.access(w, idx, sub, wd);
  endtask
  // Newest record enters position 1, category taken from the flags at the log edge
  task log_one;
    fl = fault_present & FLAGS_LIVE_MASK;
    for (int k = 8; k > 1; k--) hist[k] = hist[k - 1];
    @(posedge clk);
    #1;
    log_valid = 1'b1;
    {log_cause, log_code} = 24'($random(seed));
    hist[1] = {log_cause, fl, log_code};
    fault_present = 8'($random(seed));
    if (cnt < 8'h08) cnt++;
    @(posedge clk);
    #1;
    log_valid = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pop once per answer; an answer with no note left compares against unknown and fails
  always @(negedge clk) begin
    if (resp_valid === 1'b1) begin
      exp_rec = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK({resp_abort, resp_abort_code, resp_data}, exp_rec)
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    {rst, log_valid, fault_present, log_cause, log_code, cnt} = {1'b1, 41'h0};
    foreach (hist[k]) hist[k] = 32'h0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    req(0, IDX_FAULT_FLAGS, SUB_COUNT, 0, 0, 0, 0);
    req(0, IDX_FAULT_LOG, SUB_COUNT, 0, 0, 0, 0);
    req(0, IDX_FAULT_LOG, SUB_LAST_ENTRY, 0, 1, ABORT_NO_DATA, 0);
    fault_present = 8'($random(seed));
    repeat (10) log_one();
    `CHK(fault_log_count, COUNT_MAX)
    req(0, IDX_FAULT_FLAGS, 0, 0, 0, 0, {24'h0, fault_present & FLAGS_LIVE_MASK});
    for (int i = 1; i <= 8; i++) req(0, IDX_FAULT_LOG, 8'(i), 0, 0, 0, hist[i]);
    req(1, IDX_FAULT_FLAGS, 0, 0, 1, ABORT_READ_ONLY, 0);
    req(1, IDX_FAULT_LOG, 8'h03, 0, 1, ABORT_READ_ONLY, 0);
    req(0, IDX_FAULT_LOG, 8'h09, 0, 1, ABORT_NO_SUBINDEX, 0);
    req(0, 16'h1002, 0, 0, 1, ABORT_NO_OBJECT, 0);
    req(1, IDX_FAULT_LOG, 0, 32'h5, 1, ABORT_BAD_VALUE, 0);
    req(0, IDX_FAULT_LOG, 0, 0, 0, 0, {24'h0, cnt});
    req(1, IDX_FAULT_LOG, 0, 0, 0, 0, 0);
    cnt = 8'h00;
    foreach (hist[k]) hist[k] = 32'h0;
    `CHK(fault_log_count, COUNT_RESET)
    req(0, IDX_FAULT_LOG, SUB_FIRST_ENTRY, 0, 1, ABORT_NO_DATA, 0);
    log_one();
    req(0, IDX_FAULT_LOG, SUB_FIRST_ENTRY, 0, 0, 0, hist[1]);
    req(0, IDX_FAULT_LOG, 8'h02, 0, 0, 0, hist[2]);
    // Log and clear on the same edge: the new record survives as the only entry
    fork
      log_one();
      req(1, IDX_FAULT_LOG, SUB_COUNT, 0, 0, 0, 0);
    join
    cnt = COUNT_ONE;
    hist[2] = 32'h0;
    `CHK(fault_log_count, cnt)
    req(0, IDX_FAULT_LOG, SUB_FIRST_ENTRY, 0, 0, 0, hist[1]);
    req(0, IDX_FAULT_LOG, 8'h02, 0, 0, 0, hist[2]);
    // Second reset with a fault standing: flags and count must still start from zero
    fault_present = 8'($random(seed)) | 8'h01;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({fault_flags, fault_log_count}, {FLAGS_RESET, COUNT_RESET})
    rst = 1'b0;
    cnt = COUNT_RESET;
    foreach (hist[k]) hist[k] = 32'h0;
    req(0, IDX_FAULT_LOG, SUB_COUNT, 0, 0, 0, 0);
    req(0, IDX_FAULT_LOG, SUB_FIRST_ENTRY, 0, 1, ABORT_NO_DATA, 0);
    log_one();
    req(0, IDX_FAULT_LOG, 8'h02, 0, 0, 0, hist[2]);
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule
bind fault_flags_and_history fault_checker fault_checker_i (.clk(clk), .rst(rst),
  .fault_present(fault_present), .log_valid(log_valid), .req_valid(req_valid),
  .req_write(req_write), .req_index(req_index), .req_subindex(req_subindex),
  .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_abort(resp_abort),
  .resp_data(resp_data), .resp_abort_code(resp_abort_code), .fault_flags(fault_flags),
  .fault_log_count(fault_log_count));
